// >>> rtl/light_ctrl_pkg.sv
// constants, register map and types of the occupancy lighting controller
package light_ctrl_pkg;
  // ---------------------------------------------------------------
  // parameter store map (byte index)
  // ---------------------------------------------------------------
  localparam logic [3:0] PARAM_VALID_FLAG_IDX = 4'h0;
  localparam logic [3:0] CONTROL_MODE_SELECT_IDX = 4'h1;
  localparam logic [3:0] HARSH_SENSITIVITY_FLAG_IDX = 4'h2;
  localparam logic [3:0] MICROMOTION_BOOST_FLAG_IDX = 4'h3;
  localparam logic [3:0] OUTPUT_DELAY_MINUTES_IDX = 4'h4;
  localparam logic [3:0] OUTPUT_LINK_SELECT_IDX = 4'h5;
  localparam logic [3:0] ON_LEVEL_PERCENT_IDX = 4'h6;
  localparam logic [3:0] PREOFF_LEVEL_PERCENT_IDX = 4'h7;
  localparam logic [3:0] OFF_LEVEL_PERCENT_IDX = 4'h8;
  localparam logic [3:0] LAST_SWITCH_BANK_LO_IDX = 4'h9;
  localparam logic [3:0] LAST_SWITCH_BANK_HI_IDX = 4'ha;
  localparam logic [3:0] CONTROL_STATUS_IDX = 4'hb;
  localparam int STORE_DEPTH = 11;

  // ---------------------------------------------------------------
  // values and reset contents
  // ---------------------------------------------------------------
  localparam logic [7:0] PARAM_INVALID = 8'hff;
  localparam logic [7:0] PARAM_VALID_RESET = 8'hff;
  localparam logic [7:0] PARAM_OTHER_RESET = 8'h00;
  localparam logic [7:0] LEVEL_MAX = 8'h64;
  localparam logic [7:0] DELAY_MIN_MINUTES = 8'h01;
  localparam logic [7:0] DELAY_MAX_MINUTES = 8'h0f;
  localparam logic [7:0] BANK_DELAY_SHORT = 8'h01;
  localparam logic [7:0] BANK_DELAY_LONG = 8'h05;
  localparam logic [7:0] BANK_ON_LEVEL = 8'h64;
  localparam logic [7:0] BANK_PREOFF_LEVEL = 8'h32;
  localparam logic [7:0] BANK_OFF_LOW = 8'h00;
  localparam logic [7:0] BANK_OFF_DIM = 8'h0a;
  localparam logic [7:0] DALI_DIRECT_BROADCAST = 8'hfe;
  // switch bank bit positions
  localparam int BANK_MODE_LSB = 0;
  localparam int BANK_OFF_DIM_BIT = 2;
  localparam int BANK_MULTI_BIT = 3;
  localparam int BANK_DELAY_BIT = 7;
  localparam int BANK_LINK_LSB = 8;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int LINK_BPS = 1200;
  localparam int HALF_BIT_CYC = CLK_HZ / (2 * LINK_BPS);
  localparam int SECOND_CYC = CLK_HZ;
  localparam int LEVEL_GAP_MS = 5;
  localparam int LEVEL_GAP_CYC = (CLK_HZ / 1000) * LEVEL_GAP_MS;
  localparam int DALI_GAP_US = 9170;
  localparam int DALI_GAP_CYC = (CLK_HZ / 1_000_000) * DALI_GAP_US + 1;
  localparam logic [9:0] PASS_WINDOW_S = 10'd20;
  localparam logic [9:0] PASS_DELAY_S = 10'd10;
  localparam logic [9:0] SECONDS_PER_MINUTE = 10'd60;
  localparam logic [4:0] LEVEL_FRAME_BITS = 5'd9;
  localparam logic [4:0] DALI_FRAME_BITS = 5'd17;
  localparam logic [2:0] STOP_HALVES = 3'd4;
  localparam int FIFO_DEPTH = 8;
  localparam int FRAME_W = 17;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_OCCUPANCY = 2'b00,
    MODE_PASS = 2'b01,
    MODE_VACANCY = 2'b10,
    MODE_MOTION_OFF = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    LINK_ANALOG = 2'b00,
    LINK_LEVEL = 2'b01,
    LINK_DALI = 2'b10,
    LINK_OTHER = 2'b11
  } link_t;

  typedef enum logic [1:0] {
    LIGHT_OFF = 2'b00,
    LIGHT_ON = 2'b01,
    LIGHT_PREOFF = 2'b10
  } light_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BITS = 2'b01,
    TX_STOP = 2'b10,
    TX_GAP = 2'b11
  } tx_state_t;
endpackage : light_ctrl_pkg

// >>> rtl/occupancy_light_controller.sv
// occupancy lighting controller: parameter store, modes, timers, serial link
`timescale 1ns/1ps

module frame_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (clk_en) begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
      if (push && !pop) count_reg <= count_reg + 1'b1;
      else if (pop && !push) count_reg <= count_reg - 1'b1;
    end
  end
endmodule : frame_fifo

module occupancy_light_controller #(
  parameter int HALF_BIT_CYCLES = light_ctrl_pkg::HALF_BIT_CYC,
  parameter int SECOND_CYCLES = light_ctrl_pkg::SECOND_CYC,
  parameter int LEVEL_GAP_CYCLES = light_ctrl_pkg::LEVEL_GAP_CYC,
  parameter int DALI_GAP_CYCLES = light_ctrl_pkg::DALI_GAP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] param_sel,
  input wire logic param_wr_en,
  input wire logic [7:0] param_wdata,
  output logic [7:0] param_rdata,
  input wire logic [9:0] switch_bank,
  input wire logic motion_event,
  input wire logic switch_on,
  input wire logic switch_off,
  input wire logic remote_on,
  input wire logic remote_off,
  output light_ctrl_pkg::light_t light_state,
  output logic [7:0] light_level,
  output light_ctrl_pkg::link_t active_link,
  output logic link_tx,
  output logic link_busy
);
  import light_ctrl_pkg::*;

  // ---------------------------------------------------------------
  // parameter store
  // ---------------------------------------------------------------
  logic [7:0] store_reg [STORE_DEPTH];
  logic params_valid;
  mode_t mode;
  link_t link;
  logic [7:0] delay_minutes;
  logic [7:0] on_level;
  logic [7:0] preoff_level;
  logic [7:0] off_level;
  logic multi_state;
  logic [7:0] wr_value;

  // clamps out-of-range writes into the legal byte ranges
  function automatic logic [7:0] clamp_write(input logic [3:0] idx,
                                             input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (idx == ON_LEVEL_PERCENT_IDX || idx == PREOFF_LEVEL_PERCENT_IDX ||
        idx == OFF_LEVEL_PERCENT_IDX) begin
      if (v > LEVEL_MAX) r = LEVEL_MAX;
    end else if (idx == OUTPUT_DELAY_MINUTES_IDX) begin
      if (v < DELAY_MIN_MINUTES) r = DELAY_MIN_MINUTES;
      else if (v > DELAY_MAX_MINUTES) r = DELAY_MAX_MINUTES;
    end
    return r;
  endfunction : clamp_write

  assign wr_value = clamp_write(param_sel, param_wdata);

  genvar gi;
  generate
    for (gi = 0; gi < STORE_DEPTH; gi++) begin : g_store
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          store_reg[gi] <= (gi == 0) ? PARAM_VALID_RESET : PARAM_OTHER_RESET;
        end else if (clk_en && param_wr_en && param_sel == 4'(gi)) begin
          store_reg[gi] <= wr_value;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // active parameter selection
  // ---------------------------------------------------------------
  assign params_valid = (store_reg[PARAM_VALID_FLAG_IDX] != PARAM_INVALID);
  assign multi_state = switch_bank[BANK_MULTI_BIT];

  always_comb begin
    if (params_valid) begin
      mode = mode_t'(store_reg[CONTROL_MODE_SELECT_IDX][1:0]);
      link = link_t'(store_reg[OUTPUT_LINK_SELECT_IDX][1:0]);
      delay_minutes = store_reg[OUTPUT_DELAY_MINUTES_IDX];
      on_level = store_reg[ON_LEVEL_PERCENT_IDX];
      preoff_level = store_reg[PREOFF_LEVEL_PERCENT_IDX];
      off_level = store_reg[OFF_LEVEL_PERCENT_IDX];
    end else begin
      mode = mode_t'(switch_bank[BANK_MODE_LSB +: 2]);
      link = link_t'(switch_bank[BANK_LINK_LSB +: 2]);
      delay_minutes = switch_bank[BANK_DELAY_BIT] ? BANK_DELAY_LONG
                                                  : BANK_DELAY_SHORT;
      on_level = BANK_ON_LEVEL;
      preoff_level = BANK_PREOFF_LEVEL;
      off_level = switch_bank[BANK_OFF_DIM_BIT] ? BANK_OFF_DIM : BANK_OFF_LOW;
    end
  end

  // ---------------------------------------------------------------
  // second tick divider
  // ---------------------------------------------------------------
  logic [31:0] sec_cnt_reg;
  logic sec_tick;

  assign sec_tick = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sec_cnt_reg <= '0;
    else if (clk_en) sec_cnt_reg <= sec_tick ? '0 : sec_cnt_reg + 1'b1;
  end

  // ---------------------------------------------------------------
  // control modes and timers (all in seconds)
  // ---------------------------------------------------------------
  logic lit_reg;
  logic lit_next;
  logic [9:0] dly_reg;
  logic [9:0] dly_next;
  logic [9:0] period_reg;
  logic [9:0] period_next;
  logic [9:0] pass_reg;
  logic [9:0] pass_next;
  logic pass_done_reg;
  logic pass_done_next;
  logic [9:0] stored_delay_s;

  assign stored_delay_s = 10'(delay_minutes) * SECONDS_PER_MINUTE;

  always_comb begin
    lit_next = lit_reg;
    dly_next = dly_reg;
    period_next = period_reg;
    pass_next = pass_reg;
    pass_done_next = pass_done_reg;
    if (sec_tick) begin
      if (dly_reg == 10'd1) lit_next = 1'b0;
      if (dly_reg != '0) dly_next = dly_reg - 1'b1;
      if (pass_reg == 10'd1) pass_done_next = 1'b1;
      if (pass_reg != '0) pass_next = pass_reg - 1'b1;
    end
    if (motion_event) begin
      case (mode)
        MODE_OCCUPANCY: begin
          lit_next = 1'b1;
          dly_next = stored_delay_s;
          period_next = stored_delay_s;
        end
        MODE_PASS: begin
          lit_next = 1'b1;
          if (pass_done_reg) begin
            dly_next = stored_delay_s;
            period_next = stored_delay_s;
          end else begin
            if (pass_reg == '0) pass_next = PASS_WINDOW_S;
            dly_next = PASS_DELAY_S;
            period_next = PASS_DELAY_S;
          end
        end
        MODE_VACANCY: begin
          if (lit_reg) begin
            dly_next = stored_delay_s;
            period_next = stored_delay_s;
          end
        end
        MODE_MOTION_OFF: begin
          dly_next = dly_next;
        end
        default: begin
          dly_next = dly_next;
        end
      endcase
    end
    if (switch_on || remote_on) begin
      lit_next = 1'b1;
      dly_next = stored_delay_s;
      period_next = stored_delay_s;
    end
    if (switch_off || (remote_off && mode != MODE_MOTION_OFF)) begin
      lit_next = 1'b0;
      dly_next = '0;
    end
    if (!lit_next) begin
      pass_next = '0;
      pass_done_next = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lit_reg <= 1'b0;
      dly_reg <= '0;
      period_reg <= '0;
      pass_reg <= '0;
      pass_done_reg <= 1'b0;
    end else if (clk_en) begin
      lit_reg <= lit_next;
      dly_reg <= dly_next;
      period_reg <= period_next;
      pass_reg <= pass_next;
      pass_done_reg <= pass_done_next;
    end
  end

  // ---------------------------------------------------------------
  // light profile and level output
  // ---------------------------------------------------------------
  light_t state_now;
  logic [7:0] level_now;

  always_comb begin
    if (!lit_reg) state_now = LIGHT_OFF;
    else if (multi_state && (14'(dly_reg) * 14'd10 <= 14'(period_reg)))
      state_now = LIGHT_PREOFF;
    else state_now = LIGHT_ON;
    case (state_now)
      LIGHT_ON: level_now = on_level;
      LIGHT_PREOFF: level_now = preoff_level;
      default: level_now = off_level;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      light_state <= LIGHT_OFF;
      light_level <= '0;
      active_link <= LINK_ANALOG;
    end else if (clk_en) begin
      light_state <= state_now;
      light_level <= level_now;
      active_link <= link;
    end
  end

  // ---------------------------------------------------------------
  // frame queue: a new level is queued once per change
  // ---------------------------------------------------------------
  logic [7:0] sent_level_reg;
  logic sent_link_reg;
  logic serial_link;
  logic q_in_valid;
  logic q_in_ready;
  logic [FRAME_W-1:0] q_in_data;
  logic q_out_valid;
  logic q_out_ready;
  logic [FRAME_W-1:0] q_out_data;

  assign serial_link = (active_link == LINK_LEVEL) || (active_link == LINK_DALI);
  assign q_in_valid = serial_link && (light_level != sent_level_reg);
  // upper data byte is the broadcast direct-level address in DALI mode
  assign q_in_data = (active_link == LINK_DALI)
                     ? {1'b1, DALI_DIRECT_BROADCAST, light_level}
                     : {1'b0, 8'h00, light_level};

  // a full queue holds the change back until a slot frees
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_level_reg <= '0;
      sent_link_reg <= 1'b0;
    end else if (clk_en && q_in_valid && q_in_ready) begin
      sent_level_reg <= light_level;
      sent_link_reg <= 1'b1;
    end
  end

  frame_fifo #(.WIDTH(FRAME_W), .DEPTH(FIFO_DEPTH)) u_queue (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(q_in_valid),
    .in_ready(q_in_ready),
    .in_data(q_in_data),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out_data)
  );

  // ---------------------------------------------------------------
  // Manchester transmitter
  // ---------------------------------------------------------------
  tx_state_t tx_state_reg;
  logic [31:0] half_cnt_reg;
  logic half_reg;
  logic [4:0] bits_left_reg;
  logic [2:0] stop_left_reg;
  logic [16:0] shift_reg;
  logic dali_reg;
  logic idle_level;
  logic half_end;
  logic [31:0] gap_cycles;

  assign half_end = (half_cnt_reg == 32'(HALF_BIT_CYCLES - 1));
  assign idle_level = (active_link == LINK_DALI);
  assign gap_cycles = dali_reg ? 32'(DALI_GAP_CYCLES)
                               : 32'(LEVEL_GAP_CYCLES);
  assign q_out_ready = (tx_state_reg == TX_IDLE);
  assign link_busy = (tx_state_reg != TX_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      half_cnt_reg <= '0;
      half_reg <= 1'b0;
      bits_left_reg <= '0;
      stop_left_reg <= '0;
      shift_reg <= '0;
      dali_reg <= 1'b0;
      link_tx <= 1'b0;
    end else if (clk_en) begin
      case (tx_state_reg)
        TX_IDLE: begin
          link_tx <= idle_level;
          half_cnt_reg <= '0;
          half_reg <= 1'b0;
          if (q_out_valid) begin
            dali_reg <= q_out_data[16];
            // start bit is a coded one, sent first from the top
            shift_reg <= q_out_data[16] ? {1'b1, q_out_data[15:0]}
                                        : {1'b1, q_out_data[7:0], 8'h00};
            bits_left_reg <= q_out_data[16] ? DALI_FRAME_BITS
                                            : LEVEL_FRAME_BITS;
            // line leaves idle on the next edge, so all halves match
            tx_state_reg <= TX_BITS;
          end
        end
        TX_BITS: begin
          // first half carries bit (level) or its inverse (DALI)
          link_tx <= shift_reg[16] ^ dali_reg ^ half_reg;
          if (half_end) begin
            half_cnt_reg <= '0;
            half_reg <= ~half_reg;
            if (half_reg) begin
              shift_reg <= {shift_reg[15:0], 1'b0};
              bits_left_reg <= bits_left_reg - 1'b1;
              if (bits_left_reg == 5'd1) begin
                stop_left_reg <= STOP_HALVES;
                tx_state_reg <= TX_STOP;
              end
            end
          end else begin
            half_cnt_reg <= half_cnt_reg + 1'b1;
          end
        end
        TX_STOP: begin
          link_tx <= dali_reg;
          if (half_end) begin
            half_cnt_reg <= '0;
            stop_left_reg <= stop_left_reg - 1'b1;
            if (stop_left_reg == 3'd1) tx_state_reg <= TX_GAP;
          end else begin
            half_cnt_reg <= half_cnt_reg + 1'b1;
          end
        end
        TX_GAP: begin
          link_tx <= dali_reg;
          if (half_cnt_reg >= gap_cycles - 1) begin
            half_cnt_reg <= '0;
            tx_state_reg <= TX_IDLE;
          end else begin
            half_cnt_reg <= half_cnt_reg + 1'b1;
          end
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // parameter readback; last index shows live control state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      param_rdata <= '0;
    end else if (clk_en) begin
      if (param_sel < 4'(STORE_DEPTH)) param_rdata <= store_reg[param_sel];
      else if (param_sel == CONTROL_STATUS_IDX)
        param_rdata <= {link_busy, params_valid, sent_link_reg, 1'b0,
                        light_state, mode};
      else param_rdata <= '0;
    end
  end
endmodule : occupancy_light_controller

// >>> verification/ballast_model.sv
// ballast receiver model for the level link and DALI forward frames
`timescale 1ns/1ps
module ballast_model #(
  parameter int HB = 4
) (
  input wire logic clk,
  input wire logic line,
  input wire logic dali,
  output logic [15:0] rx_word,
  output logic rx_stb
);
  initial begin
    rx_stb = 1'b0;
    rx_word = 16'h0000;
    forever begin
      // a frame opens when the line leaves its idle level
      @(line);
      if (line != dali) begin
        rx_word = 16'h0000;
        repeat (HB / 2) @(posedge clk);
        for (int i = 0; i < (dali ? 16 : 8); i++) begin
          repeat (2 * HB) @(posedge clk);
          rx_word = {rx_word[14:0], line ^ dali};
        end
        for (int i = 0; i < 2; i++) begin
          repeat (2 * HB) @(posedge clk);
          if (line != dali)
            rx_word = 16'hxxxx;
        end
        // a direct level asks nothing, so no backward frame goes out
        rx_stb = 1'b1;
        @(posedge clk);
        rx_stb = 1'b0;
      end
    end
  end
endmodule : ballast_model

// >>> verification/light_ctrl_sva.sv
// concurrent checks at the ports of the occupancy lighting controller
`timescale 1ns/1ps
module light_ctrl_sva #(
  parameter int HALF_BIT_CYCLES = 4,
  parameter int LEVEL_GAP_CYCLES = 20,
  parameter int DALI_GAP_CYCLES = 30
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] param_sel,
  input wire logic param_wr_en,
  input wire logic [7:0] param_wdata,
  input wire logic [7:0] param_rdata,
  input wire logic motion_event,
  input wire logic switch_on,
  input wire logic switch_off,
  input wire logic remote_on,
  input wire logic remote_off,
  input wire light_ctrl_pkg::light_t light_state,
  input wire light_ctrl_pkg::link_t active_link,
  input wire logic link_tx,
  input wire logic link_busy
);
  import light_ctrl_pkg::*;
  logic prev_tx;
  logic flip;
  logic [15:0] run_len;
  // run length of the line level, saturating so long idles never wrap
  assign flip = link_tx != prev_tx;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_tx <= 1'b0;
      run_len <= 16'h0000;
    end else begin
      prev_tx <= link_tx;
      if (flip)
        run_len <= 16'h0001;
      else if (run_len != 16'hffff)
        run_len <= run_len + 16'h0001;
    end
  end
  function automatic logic [7:0] lim(input logic [7:0] v, lo, hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : lim
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_level_clamp;
    (clk_en && param_wr_en && param_sel == 4'h6) ##1
    (clk_en && !param_wr_en && param_sel == 4'h6) |=>
    param_rdata == lim($past(param_wdata, 2), 8'h00, 8'h64);
  endproperty
  a_level_clamp: assert property (p_level_clamp)
    else $error("on level readback wrong");
  property p_delay_clamp;
    (clk_en && param_wr_en && param_sel == 4'h4) ##1
    (clk_en && !param_wr_en && param_sel == 4'h4) |=>
    param_rdata == lim($past(param_wdata, 2), 8'h01, 8'h0f);
  endproperty
  a_delay_clamp: assert property (p_delay_clamp)
    else $error("delay readback wrong");
  property p_level_idle;
    (active_link == LINK_LEVEL && $past(active_link, 2) == LINK_LEVEL &&
     !link_busy && !$past(link_busy)) |-> !link_tx;
  endproperty
  a_level_idle: assert property (p_level_idle)
    else $error("level link not low when idle");
  property p_half_bit;
    (flip && link_busy && run_len <= 2 * HALF_BIT_CYCLES) |->
    (run_len == HALF_BIT_CYCLES || run_len == 2 * HALF_BIT_CYCLES);
  endproperty
  a_half_bit: assert property (p_half_bit)
    else $error("half bit length wrong");
  property p_level_gap;
    (flip && link_tx && active_link == LINK_LEVEL &&
     run_len > 2 * HALF_BIT_CYCLES) |->
    run_len >= 4 * HALF_BIT_CYCLES + LEVEL_GAP_CYCLES - 1;
  endproperty
  a_level_gap: assert property (p_level_gap)
    else $error("level link gap too short");
  property p_dali_gap;
    (flip && !link_tx && active_link == LINK_DALI &&
     run_len > 2 * HALF_BIT_CYCLES) |->
    run_len >= 4 * HALF_BIT_CYCLES + DALI_GAP_CYCLES - 1;
  endproperty
  a_dali_gap: assert property (p_dali_gap)
    else $error("dali gap too short");
  property p_switch_on;
    (clk_en && switch_on && !switch_off && !remote_off) ##1
    (clk_en && !switch_off && !remote_off) |=> light_state == LIGHT_ON;
  endproperty
  a_switch_on: assert property (p_switch_on)
    else $error("switch did not light");
  property p_switch_off;
    (clk_en && switch_off && !motion_event) ##1
    (clk_en && !switch_on && !remote_on && !motion_event) |=>
    light_state == LIGHT_OFF;
  endproperty
  a_switch_off: assert property (p_switch_off)
    else $error("switch did not turn off");
  c_level: cover property (active_link == LINK_LEVEL && flip && link_tx);
  c_dali: cover property (active_link == LINK_DALI && flip && !link_tx);
  c_lit: cover property (light_state == LIGHT_ON);
endmodule : light_ctrl_sva
bind occupancy_light_controller light_ctrl_sva #(
  .HALF_BIT_CYCLES(HALF_BIT_CYCLES),
  .LEVEL_GAP_CYCLES(LEVEL_GAP_CYCLES),
  .DALI_GAP_CYCLES(DALI_GAP_CYCLES)
) light_ctrl_sva_i (.clk, .rst_n, .clk_en, .param_sel, .param_wr_en,
  .param_wdata, .param_rdata, .motion_event, .switch_on, .switch_off,
  .remote_on, .remote_off, .light_state, .active_link, .link_tx, .link_busy);

// >>> verification/tb.sv
// self-checking bench of the occupancy lighting controller
`timescale 1ns/1ps
module tb;
  import light_ctrl_pkg::*;
  logic clk, rst_n, clk_en, param_wr_en, link_tx, link_busy, rx_stb;
  logic [3:0] param_sel;
  logic [7:0] param_wdata, param_rdata, light_level, v;
  logic [15:0] rx_word;
  logic [9:0] sw;
  logic [4:0] ev;
  light_t light_state;
  link_t active_link;
  int num_errors = 0;
  int checks_done = 0;
  int quiet = 0;
  occupancy_light_controller #(.HALF_BIT_CYCLES(4), .SECOND_CYCLES(50),
    .LEVEL_GAP_CYCLES(20), .DALI_GAP_CYCLES(30)
  ) occupancy_light_controller_i (.clk, .rst_n, .clk_en, .param_sel,
    .param_wr_en, .param_wdata, .param_rdata, .switch_bank(sw),
    .motion_event(ev[0]), .switch_on(ev[1]), .switch_off(ev[2]),
    .remote_on(ev[3]), .remote_off(ev[4]), .light_state, .light_level,
    .active_link, .link_tx, .link_busy);
  ballast_model #(.HB(4)) ballast_model_i (.clk, .line(link_tx),
    .dali(active_link == LINK_DALI), .rx_word, .rx_stb);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [7:0] lvl_exp(input logic [7:0] w);
    return (w > 8'h64) ? 8'h64 : w;
  endfunction : lvl_exp
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    param_sel = a;
    param_wdata = d;
    param_wr_en = 1'b1;
    @(negedge clk);
    param_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    param_sel = a;
    repeat (2) @(negedge clk);
    chk(param_rdata, e);
  endtask : rd
  // one-cycle event pulse, then room for the two-edge answer
  task automatic pulse(input logic [4:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 5'h00;
    repeat (2) @(negedge clk);
  endtask : pulse
  task automatic get_rx(input logic [15:0] e);
    int n;
    n = 0;
    while (rx_stb !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk({7'h00, rx_stb}, 8'h01);
    chk(rx_word[15:8], e[15:8]);
    chk(rx_word[7:0], e[7:0]);
  endtask : get_rx
  task automatic complete_run;
    if (num_errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  initial begin
    #(100 * 20000);
    num_errors++;
    complete_run();
  end
  initial begin
    clk_en = 1'b1;
    rst_n = 1'b0;
    sw = 10'h100;
    ev = 5'h00;
    param_sel = 4'h0;
    param_wr_en = 1'b0;
    param_wdata = 8'h00;
    void'($urandom(32'h5000));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (40) @(negedge clk);
    rd(4'h0, PARAM_INVALID);
    chk(active_link, LINK_LEVEL);
    pulse(5'h01);
    chk(light_level, BANK_ON_LEVEL);
    get_rx(BANK_ON_LEVEL);
    pulse(5'h04);
    chk(light_state, LIGHT_OFF);
    get_rx(8'h00);
    wr(4'h1, 8'h01);
    wr(4'h5, 8'h01);
    wr(4'h4, 8'h00);
    rd(4'h4, 8'h01);
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h65 : ((i == 3) ? 8'h50 : 8'($urandom));
      wr(4'h6, v);
      rd(4'h6, lvl_exp(v));
    end
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    pulse(5'h01);
    chk(light_level, 8'h50);
    get_rx(8'h50);
    repeat (300) @(negedge clk);
    pulse(5'h01);
    repeat (420) @(negedge clk);
    chk(light_state, LIGHT_ON);
    repeat (100) @(negedge clk);
    chk(light_state, LIGHT_OFF);
    wr(4'h1, 8'h02);
    pulse(5'h01);
    chk(light_state, LIGHT_OFF);
    pulse(5'h02);
    chk(light_state, LIGHT_ON);
    wr(4'h1, 8'h03);
    pulse(5'h10);
    chk(light_state, LIGHT_ON);
    pulse(5'h04);
    pulse(5'h01);
    chk(light_state, LIGHT_OFF);
    pulse(5'h08);
    chk(light_state, LIGHT_ON);
    // let queued level frames finish before the link changes
    while (quiet < 2) begin
      @(negedge clk);
      quiet = link_busy ? 0 : quiet + 1;
    end
    wr(4'h5, 8'h02);
    repeat (100) @(negedge clk);
    chk(active_link, LINK_DALI);
    pulse(5'h04);
    get_rx({DALI_DIRECT_BROADCAST, 8'h00});
    pulse(5'h08);
    get_rx({DALI_DIRECT_BROADCAST, 8'h50});
    sw = 10'h20c;
    wr(4'h0, 8'hff);
    get_rx({DALI_DIRECT_BROADCAST, BANK_ON_LEVEL});
    pulse(5'h01);
    // frozen cycles push the pre-off point later
    clk_en = 1'b0;
    repeat (50) @(negedge clk);
    chk(light_state, LIGHT_ON);
    clk_en = 1'b1;
    repeat (2930) @(negedge clk);
    chk(light_level, BANK_PREOFF_LEVEL);
    repeat (300) @(negedge clk);
    chk(light_level, BANK_OFF_DIM);
    complete_run();
  end
endmodule : tb
